//--- rtl/sup_pkg.sv
// Purpose: Shared constants and types of the supply supervisor.
// Assumes: 50 MHz system clock; comparator results arrive as logic levels.
// Notes:   Timeout limits are counted in timebase ticks.
`default_nettype none
package sup_pkg;
  localparam int CLK_HZ       = 50_000_000;
  localparam int OSC_HZ       = 10_240;
  localparam int OSC_DIV      = CLK_HZ / OSC_HZ;
  localparam int RST_HOLD_MS  = 50;
  localparam int WD_SHORT_MS  = 100;
  localparam int WD_LONG_MS   = 1_600;
  localparam int CW           = 15;
  localparam logic [CW-1:0] INT_HOLD  = CW'(RST_HOLD_MS * OSC_HZ / 1000);
  localparam logic [CW-1:0] INT_SHORT = CW'(WD_SHORT_MS * OSC_HZ / 1000);
  localparam logic [CW-1:0] INT_LONG  = CW'(WD_LONG_MS * OSC_HZ / 1000);
  localparam logic [CW-1:0] EXT_HOLD  = 15'h0200;
  localparam logic [CW-1:0] EXT_NORM  = 15'h0400;
  localparam logic [CW-1:0] EXT_LONG  = 15'h1000;
  // Register map of the plain port
  localparam logic [3:0] ADDR_STATUS   = 4'h0;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h1;
  localparam logic [3:0] ADDR_IRQ_CLR  = 4'h2;
  localparam logic [3:0] ADDR_IRQ_EN   = 4'h3;
  localparam int ST_SENSE = 0;
  localparam int ST_RESET = 1;
  localparam int ST_WDO   = 2;
  localparam int ST_BATT  = 3;
  localparam int ST_LONG  = 4;
  localparam int EV_LOW   = 0;
  localparam int EV_WDT   = 1;
  localparam int EV_REL   = 2;
  localparam int NEV      = 3;
  typedef struct packed {
    logic supply_sense_ok;
    logic main_below_backup_cell;
    logic ram_select_n;
    logic timebase_select;
    logic timebase_input;
    logic watchdog_kick;
    logic watchdog_kick_float;
  } sup_pins_t;
  localparam sup_pins_t SYNC_RST = 7'h1d;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sup_bus_t;
  typedef struct packed {
    logic [12:0] div;
    logic        prev;
    logic        tick;
  } sup_tb_t;
  localparam sup_tb_t TB_RST = '0;
  typedef struct packed {
    logic [CW-1:0]  hold_cnt;
    logic [CW-1:0]  wd_cnt;
    logic           in_rst;
    logic           long_to;
    logic           kick_prev;
    logic           sense_prev;
    logic           low_n;
    logic           rst_n;
    logic           rst;
    logic           wdo_n;
    logic           batt;
    logic           ram_n;
    logic [NEV-1:0] irq_st;
    logic [NEV-1:0] irq_en;
    logic           irq;
    logic [7:0]     rdata;
  } sup_state_t;
  localparam sup_state_t STATE_RST = '{
    hold_cnt: '0, wd_cnt: '0, in_rst: 1'b1, long_to: 1'b1,
    kick_prev: 1'b0, sense_prev: 1'b0, low_n: 1'b0, rst_n: 1'b0,
    rst: 1'b1, wdo_n: 1'b1, batt: 1'b0, ram_n: 1'b1,
    irq_st: '0, irq_en: '0, irq: 1'b0, rdata: 8'h00};
endpackage
`default_nettype wire

//--- rtl/sup_sync.sv
// Purpose: Two-flop synchroniser for a group of pin levels.
// Assumes: Inputs are asynchronous to clk_sys.
// Notes:   Only the second stage is visible outside.
`default_nettype none
module sup_sync (
  // Clock and reset
  input  wire  logic               clk_sys,
  input  wire  logic               rst,
  // Levels
  input  wire  sup_pkg::sup_pins_t pin_in,
  output var   sup_pkg::sup_pins_t pin_out
);
  import sup_pkg::*;

  sup_pins_t meta;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta    <= SYNC_RST;
      pin_out <= SYNC_RST;
    end else begin
      meta    <= pin_in;
      pin_out <= meta;
    end
  end
endmodule
`default_nettype wire

//--- rtl/sup_timebase.sv
// Purpose: Timebase tick: internal oscillator divider or external clock.
// Assumes: ext_in is already synchronised.
// Notes:   Tick is a one-cycle enable pulse.
`default_nettype none
module sup_timebase #(
  parameter int OSC_DIV = sup_pkg::OSC_DIV
) (
  // Clock and reset
  input  wire  logic clk_sys,
  input  wire  logic rst,
  // Source
  input  wire  logic ext_sel,
  input  wire  logic ext_in,
  // Tick
  output logic       tick
);
  import sup_pkg::*;

  sup_tb_t st;
  sup_tb_t next_st;

  always_comb begin
    next_st      = st;
    next_st.prev = ext_in;
    next_st.tick = 1'b0;
    if (ext_sel) begin
      next_st.div  = '0;
      next_st.tick = ext_in && !st.prev;
    end else if (st.div == 13'(OSC_DIV - 1)) begin
      next_st.div  = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.div = st.div + 13'd1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st <= TB_RST;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_ext_tick;
    ext_sel && !(ext_in && !st.prev) |=> !tick;
  endproperty
  a_ext_tick: assert property (p_ext_tick)
    else $error("tick without external edge");
endmodule
`default_nettype wire

//--- rtl/sup_supervisor.sv
// Purpose: Digital core of a supply supervisor with watchdog.
// Assumes: Comparator results and pins arrive asynchronously.
// Notes:   Timing follows the selected timebase tick.
//
// Added by the designer: the register offsets and strobed register access.
`default_nettype none
module sup_supervisor #(
  parameter int OSC_DIV = sup_pkg::OSC_DIV
) (
  // Clock and reset
  input  wire  logic               clk_sys,
  input  wire  logic               rst,
  // Pins and comparator results
  input  wire  sup_pkg::sup_pins_t pins,
  // Register port
  input  wire  sup_pkg::sup_bus_t  bus,
  output logic [7:0]               rd_data,
  // Supervisor outputs
  output logic                     low_supply_n,
  output logic                     reset_n,
  output logic                     reset,
  output logic                     watchdog_expired_n,
  output logic                     backup_source_active,
  output logic                     ram_select_n_out,
  // Interrupt
  output logic                     irq
);
  import sup_pkg::*;

  sup_pins_t      s;
  logic           tick;
  logic           ext_mode;
  logic           kick_edge;
  logic [CW-1:0]  wd_lim;
  logic [CW-1:0]  hold_lim;
  logic [NEV-1:0] ev;
  logic [NEV-1:0] clr;
  sup_state_t     st;
  sup_state_t     next_st;

  sup_sync u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin_in  (pins),
    .pin_out (s)
  );

  sup_timebase #(
    .OSC_DIV (OSC_DIV)
  ) u_tb (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ext_sel (ext_mode),
    .ext_in  (s.timebase_input),
    .tick    (tick)
  );

  assign ext_mode  = !s.timebase_select;
  assign kick_edge = s.watchdog_kick != st.kick_prev;

  // Limits for the current timebase and timeout phase
  always_comb begin
    if (ext_mode) begin
      hold_lim = EXT_HOLD;
      wd_lim   = st.long_to ? EXT_LONG : EXT_NORM;
    end else begin
      hold_lim = INT_HOLD;
      if (st.long_to || s.timebase_input) begin
        wd_lim = INT_LONG;
      end else begin
        wd_lim = INT_SHORT;
      end
    end
  end

  always_comb begin
    next_st           = st;
    ev                = '0;
    clr               = '0;
    next_st.kick_prev = s.watchdog_kick;
    next_st.sense_prev = s.supply_sense_ok;
    if (!s.supply_sense_ok) begin
      // Low supply: hold reset and rearm the long timeout
      next_st.in_rst   = 1'b1;
      next_st.hold_cnt = '0;
      next_st.wd_cnt   = '0;
      next_st.long_to  = 1'b1;
      next_st.wdo_n    = 1'b1;
      ev[EV_LOW]       = st.sense_prev;
    end else if (st.in_rst) begin
      next_st.wd_cnt  = '0;
      next_st.long_to = 1'b1;
      if (tick) begin
        if (st.hold_cnt == hold_lim - 15'd1) begin
          next_st.in_rst   = 1'b0;
          next_st.hold_cnt = '0;
          ev[EV_REL]       = 1'b1;
        end else begin
          next_st.hold_cnt = st.hold_cnt + 15'd1;
        end
      end
    end else if (s.watchdog_kick_float) begin
      next_st.wd_cnt = '0;
    end else if (kick_edge) begin
      next_st.wd_cnt  = '0;
      next_st.wdo_n   = 1'b1;
      next_st.long_to = 1'b0;
    end else if (tick) begin
      // At or past the limit, so a shorter limit picked mid-count still fires
      if (st.wd_cnt >= wd_lim - 15'd1) begin
        next_st.wdo_n    = 1'b0;
        next_st.in_rst   = 1'b1;
        next_st.hold_cnt = '0;
        next_st.wd_cnt   = '0;
        ev[EV_WDT]       = 1'b1;
      end else begin
        next_st.wd_cnt = st.wd_cnt + 15'd1;
      end
    end

    next_st.low_n = s.supply_sense_ok;
    next_st.rst_n = !next_st.in_rst;
    next_st.rst   = next_st.in_rst;
    next_st.batt  = !s.supply_sense_ok
                    && s.main_below_backup_cell;
    next_st.ram_n = s.supply_sense_ok ? s.ram_select_n : 1'b1;

    // Register port; a new event wins over a clear in the same cycle
    if (bus.wr && bus.addr == ADDR_IRQ_CLR) begin
      clr = bus.wdata[NEV-1:0];
    end
    if (bus.wr && bus.addr == ADDR_IRQ_EN) begin
      next_st.irq_en = bus.wdata[NEV-1:0];
    end
    next_st.irq_st = (st.irq_st & ~clr) | ev;
    next_st.irq    = |(next_st.irq_st & next_st.irq_en);
    next_st.rdata  = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        ADDR_STATUS: begin
          next_st.rdata[ST_SENSE] = s.supply_sense_ok;
          next_st.rdata[ST_RESET] = st.in_rst;
          next_st.rdata[ST_WDO]   = st.wdo_n;
          next_st.rdata[ST_BATT]  = st.batt;
          next_st.rdata[ST_LONG]  = st.long_to;
        end
        ADDR_IRQ_STAT: begin
          next_st.rdata[NEV-1:0] = st.irq_st;
        end
        ADDR_IRQ_EN: begin
          next_st.rdata[NEV-1:0] = st.irq_en;
        end
        default: begin
          next_st.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st <= STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data              = st.rdata;
  assign low_supply_n         = st.low_n;
  assign reset_n              = st.rst_n;
  assign reset                = st.rst;
  assign watchdog_expired_n   = st.wdo_n;
  assign backup_source_active = st.batt;
  assign ram_select_n_out     = st.ram_n;
  assign irq                  = st.irq;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_ram_gate;
    !s.supply_sense_ok |=> ram_select_n_out;
  endproperty
  a_ram_gate: assert property (p_ram_gate)
    else $error("RAM select not forced high at low supply");

  property p_ram_follow;
    s.supply_sense_ok |=> ram_select_n_out == $past(s.ram_select_n);
  endproperty
  a_ram_follow: assert property (p_ram_follow)
    else $error("RAM select does not follow input");

  property p_backup;
    backup_source_active
      |-> $past(!s.supply_sense_ok && s.main_below_backup_cell);
  endproperty
  a_backup: assert property (p_backup)
    else $error("backup selected without both conditions");

  property p_low_flag;
    $rose(s.supply_sense_ok) |=> low_supply_n;
  endproperty
  a_low_flag: assert property (p_low_flag)
    else $error("low-supply flag late on recovery");

  property p_reset_pair;
    reset == !reset_n;
  endproperty
  a_reset_pair: assert property (p_reset_pair)
    else $error("reset outputs not complementary");

  property p_reset_low;
    !s.supply_sense_ok |=> !reset_n;
  endproperty
  a_reset_low: assert property (p_reset_low)
    else $error("reset not asserted at low supply");

  property p_reset_hold;
    $rose(s.supply_sense_ok) && !tick |=> !reset_n [*2];
  endproperty
  a_reset_hold: assert property (p_reset_hold)
    else $error("reset released before hold time");

  property p_wdo_lowsup;
    !s.supply_sense_ok |=> watchdog_expired_n;
  endproperty
  a_wdo_lowsup: assert property (p_wdo_lowsup)
    else $error("expiry flag low during low supply");

  property p_wdo_kick;
    s.supply_sense_ok && !st.in_rst && !s.watchdog_kick_float
      && kick_edge |=> watchdog_expired_n && st.wd_cnt == '0;
  endproperty
  a_wdo_kick: assert property (p_wdo_kick)
    else $error("kick edge did not restart watchdog");

  property p_float;
    s.watchdog_kick_float && watchdog_expired_n |=> watchdog_expired_n;
  endproperty
  a_float: assert property (p_float)
    else $error("expiry while kick floating");

  property p_expire;
    s.supply_sense_ok && !st.in_rst && !s.watchdog_kick_float
      && !kick_edge && tick && st.wd_cnt >= wd_lim - 15'd1
      |=> !watchdog_expired_n && !reset_n;
  endproperty
  a_expire: assert property (p_expire)
    else $error("timeout did not expire watchdog");

  property p_long_after;
    st.in_rst |=> st.long_to;
  endproperty
  a_long_after: assert property (p_long_after)
    else $error("short timeout during reset");

  property p_low_fall;
    !s.supply_sense_ok |=> !low_supply_n;
  endproperty
  a_low_fall: assert property (p_low_fall)
    else $error("low-supply flag not set at low supply");

  property p_release;
    s.supply_sense_ok && st.in_rst && tick
      && st.hold_cnt == hold_lim - 15'd1 |=> reset_n;
  endproperty
  a_release: assert property (p_release)
    else $error("reset not released after hold time");

  property p_no_early;
    st.in_rst && !(s.supply_sense_ok && tick
      && st.hold_cnt == hold_lim - 15'd1) |=> !reset_n;
  endproperty
  a_no_early: assert property (p_no_early)
    else $error("reset released early");

  property p_backup_source_active;
    !s.supply_sense_ok && s.main_below_backup_cell
      |=> backup_source_active;
  endproperty
  a_backup_source_active: assert property (p_backup_source_active)
    else $error("backup cell not selected");

  property p_kick_short;
    s.supply_sense_ok && !st.in_rst && !s.watchdog_kick_float
      && kick_edge |=> !st.long_to;
  endproperty
  a_kick_short: assert property (p_kick_short)
    else $error("long timeout kept after kick edge");

  property p_hold_wdo;
    s.supply_sense_ok && st.in_rst
      |=> watchdog_expired_n == $past(watchdog_expired_n);
  endproperty
  a_hold_wdo: assert property (p_hold_wdo)
    else $error("expiry flag changed during reset pulse");

  property p_wdo_steady;
    s.supply_sense_ok && !st.in_rst && !kick_edge
      && !(tick && st.wd_cnt >= wd_lim - 15'd1)
      |=> watchdog_expired_n == $past(watchdog_expired_n);
  endproperty
  a_wdo_steady: assert property (p_wdo_steady)
    else $error("expiry flag changed without kick edge");

  property p_short_lim;
    !ext_mode && !st.long_to && !s.timebase_input |-> wd_lim == INT_SHORT;
  endproperty
  a_short_lim: assert property (p_short_lim)
    else $error("fast timeout not selected");

  property p_slow_lim;
    !ext_mode && s.timebase_input |-> wd_lim == INT_LONG;
  endproperty
  a_slow_lim: assert property (p_slow_lim)
    else $error("slow timeout not selected");

  property p_ext_lim;
    ext_mode |-> hold_lim == EXT_HOLD
      && wd_lim == (st.long_to ? EXT_LONG : EXT_NORM);
  endproperty
  a_ext_lim: assert property (p_ext_lim)
    else $error("external limits not selected");

  property p_ev_sticky;
    ev != '0 |=> (st.irq_st & $past(ev)) == $past(ev);
  endproperty
  a_ev_sticky: assert property (p_ev_sticky)
    else $error("event lost against clear");

  c_expire: cover property (!watchdog_expired_n ##1 watchdog_expired_n);
  c_release: cover property ($rose(reset_n));
  c_lowsup: cover property ($fell(low_supply_n));
  c_ext: cover property (ext_mode && tick);
  c_backup: cover property ($rose(backup_source_active));
endmodule
`default_nettype wire

//--- verification/sup_host_model.sv
// Purpose: Host processor and RAM side facing the supervisor.
// Assumes: The host kicks only while it is out of reset.
// Notes:   External timebase runs only when asked, period 6 clocks.
`default_nettype none
module sup_host_model #(
  parameter int KICK_GAP = 3000
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Bench control
  input  wire logic cpu_reset_n,
  input  wire logic kick_en,
  input  wire logic ram_req,
  input  wire logic ext_run,
  // Pins
  output var  logic kick,
  output var  logic ram_select_n,
  output var  logic ext_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  int gap;
  int ph;
  assign ram_select_n = ~ram_req;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      kick <= 1'b0;
      gap <= 0;
      ph <= 0;
      ext_clk <= 1'b0;
    end else begin
      if (kick_en && cpu_reset_n) begin
        gap <= (gap == KICK_GAP - 1) ? 0 : gap + 1;
        if (gap == KICK_GAP - 1)
          kick <= ~kick;
      end
      // Stands still unless the external timebase is in use
      if (ext_run) begin
        ph <= (ph == 2) ? 0 : ph + 1;
        if (ph == 2)
          ext_clk <= ~ext_clk;
      end
    end
  end
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// Purpose: Self-checking bench of the supply supervisor.
// Assumes: OSC_DIV of 4, so one internal tick is 4 clocks.
// Notes:   Row table first, then timing cases by hand.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import sup_pkg::*;
  logic        clk_sys, rst, sense_ok, below, tb_sel, tb_slow;
  logic        kick_float, kick_en, ram_req, ext_run, kick, ram_n;
  logic        ext_clk, low_n, reset_n, reset, wdo_n, batt, ram_out, irq;
  logic [7:0]  rd_data, rv;
  logic [5:0]  rows [5];
  sup_bus_t    bus;
  sup_pins_t   pins;
  int          err_count, samples_checked, n, lows;
  assign pins = '{supply_sense_ok: sense_ok, main_below_backup_cell: below,
    ram_select_n: ram_n, timebase_select: tb_sel,
    timebase_input: tb_sel ? tb_slow : ext_clk,
    watchdog_kick: kick, watchdog_kick_float: kick_float};
  sup_supervisor #(.OSC_DIV(4)) DUT (.clk_sys(clk_sys), .rst(rst),
    .pins(pins), .bus(bus), .rd_data(rd_data), .low_supply_n(low_n),
    .reset_n(reset_n), .reset(reset), .watchdog_expired_n(wdo_n),
    .backup_source_active(batt), .ram_select_n_out(ram_out), .irq(irq));
  sup_host_model host (.clk_sys(clk_sys), .rst(rst), .cpu_reset_n(reset_n),
    .kick_en(kick_en), .ram_req(ram_req), .ext_run(ext_run), .kick(kick),
    .ram_select_n(ram_n), .ext_clk(ext_clk));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (wdo_n === 1'b0)
      lows++;
  end
  task final_report;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk1(input string nm, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %b, seen %b", nm, exp, got);
    end
  endtask
  task chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task step(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask
  task bus_wr(input logic [3:0] a, input logic [7:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    step(1);
    bus <= '0;
    step(1);
  endtask
  task bus_rd(input logic [3:0] a, output logic [7:0] d);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    step(1);
    bus <= '0;
    d = rd_data;
    step(1);
  endtask
  // Waits for reset_n (w 0) or the expiry flag (w 1) to reach v
  task wait_for(input int w, input logic v, input int max, output int c);
    c = 0;
    while (((w == 0) ? reset_n : wdo_n) !== v && c < max) begin
      step(1);
      c++;
    end
  endtask
  task kick_once;
    logic k;
    int   c;
    k = kick;
    c = 0;
    kick_en <= 1'b1;
    while (kick === k && c < 3100) begin
      step(1);
      c++;
    end
    kick_en <= 1'b0;
  endtask
  initial begin
    repeat (80000) @(posedge clk_sys);
    err_count++;
    final_report();
  end
  initial begin
    {rst, sense_ok, below, tb_sel, tb_slow, kick_float} = 6'h24;
    {kick_en, ram_req, ext_run} = 3'h0;
    bus = '0;
    err_count = 0;
    samples_checked = 0;
    // sense, main below cell, select active, low_n, ram_n, backup
    rows = '{6'h2c, 6'h26, 6'h0a, 6'h1b, 6'h3c};
    step(4);
    chk1("reset", 1'b1, reset);
    chk1("low_supply_n", 1'b0, low_n);
    chk1("ram_select_n_out", 1'b1, ram_out);
    rst <= 1'b0;
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      {sense_ok, below, ram_req} <= rows[i][5:3];
      step(5);
      chk1("low_supply_n", rows[i][2], low_n);
      chk1("ram_select_n_out", rows[i][1], ram_out);
      chk1("backup_source_active", rows[i][0], batt);
      chk1("reset", 1'b1, reset);
      chk1("watchdog_expired_n", 1'b1, wdo_n);
    end
    $display("test rows done");
    {sense_ok, below} <= 2'h0;
    step(5);
    sense_ok <= 1'b1;
    wait_for(0, 1'b1, 2200, n);
    chk1("hold window", 1'b1, n >= 2040 && n <= 2080);
    step(5000);
    chk1("long timeout", 1'b1, wdo_n);
    bus_wr(ADDR_IRQ_EN, 8'h02);
    bus_rd(ADDR_IRQ_EN, rv);
    chk8("irq_en", 8'h02, rv);
    bus_rd(4'h9, rv);
    chk8("unmapped", 8'h00, rv);
    $display("test hold and bus done");
    lows = 0;
    kick_en <= 1'b1;
    step(15000);
    chk1("no expiry while kicked", 1'b1, lows == 0);
    kick_once();
    wait_for(1, 1'b0, 4300, n);
    chk1("short window", 1'b1, n >= 4070 && n <= 4140);
    step(2);
    chk1("irq", 1'b1, irq);
    chk1("reset_n pulse", 1'b0, reset_n);
    bus_rd(ADDR_IRQ_STAT, rv);
    chk8("irq_stat", 8'h02, rv & 8'h02);
    bus_wr(ADDR_IRQ_CLR, 8'h02);
    chk1("irq cleared", 1'b0, irq);
    wait_for(0, 1'b1, 2200, n);
    chk1("reset pulse", 1'b1, n >= 2000 && n <= 2100);
    chk1("expiry held", 1'b0, wdo_n);
    kick_once();
    step(4);
    chk1("expiry ends on kick", 1'b1, wdo_n);
    $display("test expiry done");
    kick_float <= 1'b1;
    step(6000);
    chk1("floating kick", 1'b1, wdo_n);
    kick_float <= 1'b0;
    tb_slow <= 1'b1;
    kick_once();
    step(6000);
    chk1("slow timeout", 1'b1, wdo_n);
    $display("test float and slow done");
    // Restart the count before the shorter external limit applies
    kick_once();
    tb_sel <= 1'b0;
    ext_run <= 1'b1;
    kick_once();
    wait_for(1, 1'b0, 6400, n);
    chk1("external window", 1'b1, n >= 6100 && n <= 6200);
    sense_ok <= 1'b0;
    step(5);
    chk1("expiry forced high", 1'b1, wdo_n);
    $display("test external done");
    final_report();
  end
endmodule
`default_nettype wire
